// file: chain_link_pkg.sv
// Constants, types and the check-code step shared by the chain link layer
// Operation
// - Traffic is whole eight-bit bytes, most significant bit first.
// - Write data is taken into registers only when chip select rises.
// - Check code is a 15-bit CRC seeded with 0x0010 over all bits.
// - Feedback is input XOR bit 14; taps at 0,3,4,7,8,10,14; rest shift.
// - Check word is the code shifted left with a zero appended.
// - First check byte holds code bits 14..7, second bits 6..0 and zero.
// - Command or data is accepted only when its check bytes match.
// - Read data is followed at once by its own computed check bytes.
// - On a read each device sends its own group, then forwards above.
// - Every device takes the same command bytes at the same time; here each device passes every bit up one link clock later.
// - Data phases act as a cascaded shift register up and down.
// - After conversion start with chip select low, output shows busy low.
// - Output returns high as soon as chip select rises.
// - Poll-status command holds output low while busy, high when done.
// - On the pulse link the status answers each data pulse only.
// - Chip select rising ends the polling command.
// - With N devices, status is zero for the first N polling clocks.
// - Bottom device reports busy while any device in the stack converts.
// - Long low pulse means chip select falls, long high means it rises.
// - Command code is 11 bits; top five command bits are zero.
package chain_link_pkg;

   localparam int BYTE_BITS = 8;
   localparam int CRC_W = 15;
   localparam int GROUP_DATA_BITS = 6 * BYTE_BITS;
   localparam int GROUP_BITS = 8 * BYTE_BITS;
   localparam int CMD_W = 2 * BYTE_BITS;
   localparam int CC_W = 11;

   localparam logic [CRC_W-1:0] CRC_SEED = 15'h0010;
   localparam logic [CRC_W-1:0] CRC_TAPS = 15'h4599;

   localparam logic [5:0] CMD_LAST_BIT = 6'h1f;
   localparam logic [5:0] GROUP_LAST_BIT = 6'h3f;
   localparam logic [5:0] CMD_CRC_BITS = 6'h10;
   localparam logic [5:0] DATA_CRC_BITS = 6'h30;

   localparam logic [4:0] CMD_ZERO_FIELD = 5'h00;
   localparam logic [CC_W-1:0] CC_WRITE_CFG_A = 11'h001;
   localparam logic [CC_W-1:0] CC_READ_CFG_A = 11'h002;
   localparam logic [CC_W-1:0] CC_CONV_MASK = 11'h668;
   localparam logic [CC_W-1:0] CC_CONV_VALUE = 11'h260;
   localparam logic [CC_W-1:0] CC_POLL_STATUS = 11'h714;

   localparam logic [GROUP_DATA_BITS-1:0] CFG_A_RESET = 48'h0000_0000_0000;

   typedef enum logic [2:0] {
      MODE_CMD = 3'b000,
      MODE_WRITE = 3'b001,
      MODE_READ = 3'b010,
      MODE_POLL = 3'b011,
      MODE_IGNORE = 3'b100
   } link_mode_t;

   // One bit into the check-code register
   function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] crc, input logic din);
      logic crc_feedback_bit;
      crc_feedback_bit = din ^ crc[CRC_W-1];
      crc_step = {crc[CRC_W-2:0], 1'b0} ^ ({CRC_W{crc_feedback_bit}} & CRC_TAPS);
   endfunction

   // Check code of a whole data group, first byte first
   function automatic logic [CRC_W-1:0] crc_group(input logic [GROUP_DATA_BITS-1:0] data);
      logic [CRC_W-1:0] acc;
      acc = CRC_SEED;
      for (int i = GROUP_DATA_BITS - 1; i >= 0; i--) begin
         acc = crc_step(acc, data[i]);
      end
      crc_group = acc;
   endfunction

endpackage

// file: chain_packet_link_layer.sv
// Serial link layer of one chained monitor device: framing, check codes, chaining, polling
`timescale 1ns/100ps
module chain_packet_link_layer
   import chain_link_pkg::*;
(
   // System clock domain
   input wire logic sys_clk,
   input wire logic reset,
   // Link toward the host (below)
   input wire logic link_sck,
   input wire logic chip_select_n,
   input wire logic sdi,
   output logic sdo,
   // Link toward the device above
   input wire logic up_sdi,
   output logic up_sdo,
   output logic up_cs_n,
   // Core side
   input wire logic conv_done,
   output logic conv_start,
   output logic conv_busy,
   output logic [GROUP_DATA_BITS-1:0] config_group_a_byte
);

   // Link-domain framing state, cleared while chip select is high
   link_mode_t mode_ff;
   link_mode_t nxt_mode;
   logic [5:0] bit_cnt_ff;
   logic [CRC_W-1:0] crc_ff;
   logic [GROUP_BITS-1:0] in_sr_ff;
   logic [GROUP_BITS-2:0] out_sr_ff;
   logic sdo_ff;
   logic up_sdo_ff;

   // Link-domain state that must outlive the frame
   logic wr_ok_ff;
   logic [GROUP_DATA_BITS-1:0] wr_data_ff;
   logic req_tog_ff;
   logic busy_meta_ff;
   logic busy_sync_ff;
   logic ack_meta_ff;
   logic ack_sync_ff;

   // System-domain state
   logic cs_meta_ff;
   logic cs_sync_ff;
   logic cs_prev_ff;
   logic up_cs_n_ff;
   logic req_meta_ff;
   logic req_sync_ff;
   logic ack_tog_ff;
   logic conv_start_ff;
   logic conv_busy_ff;
   logic [GROUP_DATA_BITS-1:0] cfg_a_ff;

   // Combinational terms
   logic [GROUP_BITS-1:0] nxt_sr;
   logic [CRC_W-1:0] crc_base;
   logic [CRC_W-1:0] nxt_crc;
   logic [5:0] crc_limit;
   logic cmd_end;
   logic cmd_ok;
   logic [CC_W-1:0] command_code_field;
   logic is_conv_cmd;
   logic grp_end;
   logic grp_ok;
   logic [GROUP_BITS-1:0] own_word;
   logic conv_idle;
   logic cs_rise;
   logic new_req;

   // ---------------------------------------------------------------
   // Receive path
   // ---------------------------------------------------------------

   always_comb begin
      nxt_sr = {in_sr_ff[GROUP_BITS-2:0], sdi};
   end

   always_comb begin
      crc_base = (bit_cnt_ff == 6'h00) ? CRC_SEED : crc_ff;
      nxt_crc = crc_step(crc_base, sdi);
      crc_limit = (mode_ff == MODE_CMD) ? CMD_CRC_BITS : DATA_CRC_BITS;
   end

   // Command word sits in bits 31..16 of the window, check word in 15..0
   always_comb begin
      cmd_end = (mode_ff == MODE_CMD) && (bit_cnt_ff == CMD_LAST_BIT);
      command_code_field = nxt_sr[CMD_W+CC_W-1:CMD_W];
      // Check word is code bits 14..7 then 6..0 and a zero
      cmd_ok = (nxt_sr[CMD_W-1:0] == {crc_ff, 1'b0})
         && (nxt_sr[2*CMD_W-1:CMD_W+CC_W] == CMD_ZERO_FIELD);
      is_conv_cmd = (command_code_field & CC_CONV_MASK) == CC_CONV_VALUE;
   end

   always_comb begin
      grp_end = (mode_ff == MODE_WRITE) && (bit_cnt_ff == GROUP_LAST_BIT);
      grp_ok = nxt_sr[CMD_W-1:0] == {crc_ff, 1'b0};
   end

   always_comb begin
      nxt_mode = mode_ff;
      if (cmd_end) begin
         if (!cmd_ok) begin
            nxt_mode = MODE_IGNORE;
         end else if (command_code_field == CC_WRITE_CFG_A) begin
            nxt_mode = MODE_WRITE;
         end else if (command_code_field == CC_READ_CFG_A) begin
            nxt_mode = MODE_READ;
         end else if (is_conv_cmd || (command_code_field == CC_POLL_STATUS)) begin
            nxt_mode = MODE_POLL;
         end else begin
            nxt_mode = MODE_IGNORE;
         end
      end
   end

   // Chip select high is the long high pulse: it ends any command at once
   always_ff @(posedge link_sck or posedge chip_select_n) begin
      if (chip_select_n) begin
         mode_ff <= MODE_CMD;
      end else begin
         mode_ff <= nxt_mode;
      end
   end

   // Counts bits within the command frame or the current data group
   always_ff @(posedge link_sck or posedge chip_select_n) begin
      if (chip_select_n) begin
         bit_cnt_ff <= 6'h00;
      end else if (cmd_end) begin
         bit_cnt_ff <= 6'h00;
      end else begin
         bit_cnt_ff <= bit_cnt_ff + 6'h01;
      end
   end

   // Code runs over the command word or the six data bytes, then holds
   always_ff @(posedge link_sck or posedge chip_select_n) begin
      if (chip_select_n) begin
         crc_ff <= CRC_SEED;
      end else if (bit_cnt_ff < crc_limit) begin
         crc_ff <= nxt_crc;
      end
   end

   always_ff @(posedge link_sck or posedge chip_select_n) begin
      if (chip_select_n) begin
         in_sr_ff <= '0;
      end else begin
         in_sr_ff <= nxt_sr;
      end
   end

   // Every bit is passed upward so all devices see the same command
   always_ff @(posedge link_sck or posedge chip_select_n) begin
      if (chip_select_n) begin
         up_sdo_ff <= 1'b1;
      end else begin
         up_sdo_ff <= sdi;
      end
   end

   // The last whole group of a write belongs to this device
   always_ff @(posedge link_sck or posedge reset) begin
      if (reset) begin
         wr_ok_ff <= 1'b0;
         wr_data_ff <= CFG_A_RESET;
      end else if (cmd_end) begin
         wr_ok_ff <= 1'b0;
      end else if (grp_end) begin
         wr_ok_ff <= grp_ok;
         wr_data_ff <= nxt_sr[GROUP_BITS-1:CMD_W];
      end else if ((mode_ff == MODE_WRITE) && (bit_cnt_ff == 6'h00)) begin
         wr_ok_ff <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Transmit path
   // ---------------------------------------------------------------

   // Own group is stable during a frame: it changes only at chip select rise
   always_comb begin
      own_word = {cfg_a_ff, crc_group(cfg_a_ff), 1'b0};
   end

   // Own bits first, then whatever arrives from above
   always_ff @(posedge link_sck or posedge chip_select_n) begin
      if (chip_select_n) begin
         out_sr_ff <= '0;
      end else if (cmd_end) begin
         out_sr_ff <= own_word[GROUP_BITS-2:0];
      end else begin
         out_sr_ff <= {out_sr_ff[GROUP_BITS-3:0], up_sdi};
      end
   end

   // Status is valid once both crossings agree nothing is pending
   always_comb begin
      conv_idle = (ack_sync_ff == req_tog_ff) && !busy_sync_ff;
   end

   // Idle level is high; chip select high forces it high at once
   always_ff @(posedge link_sck or posedge chip_select_n) begin
      if (chip_select_n) begin
         sdo_ff <= 1'b1;
      end else if (cmd_end) begin
         if (nxt_mode == MODE_READ) begin
            sdo_ff <= own_word[GROUP_BITS-1];
         end else if (nxt_mode == MODE_POLL) begin
            sdo_ff <= 1'b0;
         end else begin
            sdo_ff <= 1'b1;
         end
      end else begin
         case (mode_ff)
            MODE_READ: begin
               sdo_ff <= out_sr_ff[GROUP_BITS-2];
            end
            MODE_POLL: begin
               // One answer per data pulse; the chain adds one clock per hop
               sdo_ff <= conv_idle & up_sdi;
            end
            default: begin
               sdo_ff <= 1'b1;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Conversion start and status crossing
   // ---------------------------------------------------------------

   always_ff @(posedge link_sck or posedge reset) begin
      if (reset) begin
         req_tog_ff <= 1'b0;
      end else if (cmd_end && cmd_ok && is_conv_cmd) begin
         req_tog_ff <= ~req_tog_ff;
      end
   end

   always_ff @(posedge link_sck or posedge reset) begin
      if (reset) begin
         busy_meta_ff <= 1'b0;
         busy_sync_ff <= 1'b0;
         ack_meta_ff <= 1'b0;
         ack_sync_ff <= 1'b0;
      end else begin
         busy_meta_ff <= conv_busy_ff;
         busy_sync_ff <= busy_meta_ff;
         ack_meta_ff <= ack_tog_ff;
         ack_sync_ff <= ack_meta_ff;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         req_meta_ff <= 1'b0;
         req_sync_ff <= 1'b0;
      end else begin
         req_meta_ff <= req_tog_ff;
         req_sync_ff <= req_meta_ff;
      end
   end

   always_comb begin
      new_req = req_sync_ff != ack_tog_ff;
   end

   // Busy is raised on the same edge as the echo so the link never sees a false idle
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ack_tog_ff <= 1'b0;
         conv_start_ff <= 1'b0;
         conv_busy_ff <= 1'b0;
      end else begin
         ack_tog_ff <= req_sync_ff;
         conv_start_ff <= new_req;
         if (new_req) begin
            conv_busy_ff <= 1'b1;
         end else if (conv_done) begin
            conv_busy_ff <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Chip select in the system domain and write commit
   // ---------------------------------------------------------------

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cs_meta_ff <= 1'b1;
         cs_sync_ff <= 1'b1;
         cs_prev_ff <= 1'b1;
         up_cs_n_ff <= 1'b1;
      end else begin
         cs_meta_ff <= chip_select_n;
         cs_sync_ff <= cs_meta_ff;
         cs_prev_ff <= cs_sync_ff;
         up_cs_n_ff <= cs_sync_ff;
      end
   end

   always_comb begin
      cs_rise = cs_sync_ff && !cs_prev_ff;
   end

   // Link clock is still by now, so the captured group is stable
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cfg_a_ff <= CFG_A_RESET;
      end else if (cs_rise && wr_ok_ff) begin
         cfg_a_ff <= wr_data_ff;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------

   always_comb begin
      sdo = sdo_ff;
      up_sdo = up_sdo_ff;
      up_cs_n = up_cs_n_ff;
      conv_start = conv_start_ff;
      conv_busy = conv_busy_ff;
      config_group_a_byte = cfg_a_ff;
   end

endmodule

// file: chain_link_asserts.sv
// Concurrent checks on the ports of the chain link layer
`timescale 1ns/100ps
module chain_link_asserts
   import chain_link_pkg::*;
(
   // System clock domain
   input wire logic sys_clk,
   input wire logic reset,
   // Link toward the host
   input wire logic link_sck,
   input wire logic chip_select_n,
   input wire logic sdi,
   input wire logic sdo,
   // Link toward the device above
   input wire logic up_sdo,
   input wire logic up_cs_n,
   // Core side
   input wire logic conv_done,
   input wire logic conv_start,
   input wire logic conv_busy,
   input wire logic [GROUP_DATA_BITS-1:0] config_group_a_byte
);
   logic in_frame_ff;

   // High from the second edge of a frame, so the forward check skips the first bit
   always_ff @(posedge link_sck or posedge chip_select_n) begin
      if (chip_select_n) begin
         in_frame_ff <= 1'b0;
      end else begin
         in_frame_ff <= 1'b1;
      end
   end

   chk_fwd_up: assert property (@(posedge link_sck) disable iff (reset)
      in_frame_ff |-> up_sdo == $past(sdi))
      else $error("upward data is not the previous received bit");
   chk_sdo_idle: assert property (@(posedge sys_clk) disable iff (reset) chip_select_n |-> sdo)
      else $error("sdo low while chip select high");
   chk_up_idle: assert property (@(posedge sys_clk) disable iff (reset) chip_select_n |-> up_sdo)
      else $error("upward data low while chip select high");
   chk_cs_relay: assert property (@(posedge sys_clk) disable iff (reset)
      up_cs_n == $past(chip_select_n, 3))
      else $error("upward chip select not three cycles behind");
   chk_start_busy: assert property (@(posedge sys_clk) disable iff (reset)
      conv_start |-> conv_busy)
      else $error("start without busy");
   chk_start_pulse: assert property (@(posedge sys_clk) disable iff (reset)
      conv_start |=> !conv_start)
      else $error("start longer than one cycle");
   chk_busy_cause: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(conv_busy) |-> conv_start)
      else $error("busy rose without start");
   // A new start in the cycle of done keeps busy up, and then start shows too
   chk_busy_clear: assert property (@(posedge sys_clk) disable iff (reset)
      conv_done |=> conv_busy == conv_start)
      else $error("busy after done does not follow start");
   chk_cfg_commit: assert property (@(posedge sys_clk) disable iff (reset)
      !$stable(config_group_a_byte) |-> $past(chip_select_n))
      else $error("config changed while chip select low");
endmodule

bind chain_packet_link_layer chain_link_asserts u_chk (
   .sys_clk(sys_clk), .reset(reset), .link_sck(link_sck), .chip_select_n(chip_select_n),
   .sdi(sdi), .sdo(sdo), .up_sdo(up_sdo), .up_cs_n(up_cs_n), .conv_done(conv_done),
   .conv_start(conv_start), .conv_busy(conv_busy), .config_group_a_byte(config_group_a_byte)
);

// file: chain_link_host.sv
// Host-side model of the serial link: wake pulses, frames and bit shifting
`timescale 1ns/100ps
module chain_link_host (
   // Link toward the device
   output logic link_sck,
   output logic chip_select_n,
   output logic sdi,
   input wire logic sdo
);
   // Chip select rises after time zero so the frame clears in the device see an edge
   initial begin
      link_sck = 1'b0;
      sdi = 1'b1;
      #1;
      chip_select_n = 1'b1;
   end

   // One low/high pair per device, spaced inside the idle window
   task automatic wake(input int devices);
      repeat (devices) begin
         chip_select_n = 1'b0;
         #400;
         chip_select_n = 1'b1;
         #400;
      end
   endtask

   task automatic open_frame();
      chip_select_n = 1'b0;
      #100;
   endtask

   // Data line is not held after the frame
   task automatic close_frame();
      #40;
      chip_select_n = 1'b1;
      sdi = ~sdi;
      #300;
   endtask

   // Shifts 32 bits out first bit first and samples the answer just before each rise
   task automatic word(input logic [31:0] tx, output logic [31:0] rx);
      for (int i = 31; i >= 0; i--) begin
         sdi = tx[i];
         #39;
         rx[i] = sdo;
         #1;
         link_sck = 1'b1;
         #40;
         link_sck = 1'b0;
      end
   endtask
endmodule

// file: chain_packet_link_layer_bench.sv
// Self-checking bench of the chain link layer
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module chain_packet_link_layer_bench
   import chain_link_pkg::*;
;
   logic sys_clk, reset, up_sdi, conv_done, link_sck, chip_select_n, sdi, sdo;
   logic up_sdo, up_cs_n, conv_start, conv_busy;
   logic [GROUP_DATA_BITS-1:0] cfg;
   logic [31:0] rx;
   logic [63:0] g;
   int err_total = 0;
   int comparisons = 0;
   localparam logic [47:0] DA = 48'h1234_5678_9abc;

   chain_packet_link_layer DUT (.sys_clk(sys_clk), .reset(reset), .link_sck(link_sck),
      .chip_select_n(chip_select_n), .sdi(sdi), .sdo(sdo), .up_sdi(up_sdi), .up_sdo(up_sdo),
      .up_cs_n(up_cs_n), .conv_done(conv_done), .conv_start(conv_start), .conv_busy(conv_busy),
      .config_group_a_byte(cfg));
   chain_link_host host (.link_sck(link_sck), .chip_select_n(chip_select_n), .sdi(sdi), .sdo(sdo));

   always #12.5 sys_clk = ~sys_clk;

   function automatic logic [14:0] packet_check_code(input logic [63:0] d, input int n);
      logic [14:0] c;
      logic f;
      c = 15'h0010;
      for (int i = n - 1; i >= 0; i--) begin
         f = d[i] ^ c[14];
         c = {c[13:0], 1'b0} ^ ({15{f}} & 15'h4599);
      end
      return c;
   endfunction

   function automatic logic [31:0] cmd(input logic [15:0] c);
      return {c, packet_check_code({48'h0, c}, 16), 1'b0};
   endfunction

   function automatic logic [63:0] grp(input logic [47:0] d);
      return {d, packet_check_code({16'h0, d}, 48), 1'b0};
   endfunction

   task automatic t_write();
      logic [63:0] far;
      far = grp(48'hfeed_0000_beef);
      g = grp(DA);
      host.open_frame();
      `CHK(up_cs_n, 1'b0)
      host.word({16'h0001, 16'h3d6e}, rx);
      host.word(far[63:32], rx);
      host.word(far[31:0], rx);
      host.word(g[63:32], rx);
      host.word(g[31:0], rx);
      `CHK(cfg, 48'h0)
      host.close_frame();
      `CHK(cfg, DA)
   endtask

   task automatic t_bad_write();
      g = grp(48'h0f0f_a5a5_3c3c) ^ 64'h2;
      host.open_frame();
      host.word(cmd(16'h0001), rx);
      host.word(g[63:32], rx);
      host.word(g[31:0], rx);
      host.close_frame();
      `CHK(cfg, DA)
   endtask

   task automatic t_read();
      g = grp(DA);
      @(negedge sys_clk) up_sdi = 1'b0;
      host.open_frame();
      host.word(cmd(16'h0002), rx);
      host.word(32'h0, rx);
      `CHK(rx, g[63:32])
      host.word(32'h0, rx);
      `CHK(rx, g[31:0])
      host.word(32'h0, rx);
      `CHK(rx, 32'h0)
      host.close_frame();
      @(negedge sys_clk) up_sdi = 1'b1;
   endtask

   task automatic t_bad_cmd();
      host.open_frame();
      host.word(cmd(16'h0002) ^ 32'h2, rx);
      host.word(32'h0, rx);
      `CHK(rx, 32'hffff_ffff)
      host.close_frame();
   endtask

   task automatic t_poll();
      host.open_frame();
      host.word(cmd(16'h0260), rx);
      host.word(32'h0, rx);
      `CHK(rx, 32'h0)
      `CHK(conv_busy, 1'b1)
      host.close_frame();
      `CHK({sdo, conv_busy}, 2'b11)
      host.open_frame();
      host.word(cmd(16'h0714), rx);
      host.word(32'h0, rx);
      `CHK(rx, 32'h0)
      @(negedge sys_clk) conv_done = 1'b1;
      @(negedge sys_clk) conv_done = 1'b0;
      host.word(32'h0, rx);
      `CHK(rx[3:0], 4'hf)
      `CHK(conv_busy, 1'b0)
      // A device above that is still busy pulls the status low again
      @(negedge sys_clk) up_sdi = 1'b0;
      host.word(32'h0, rx);
      `CHK(rx[3:0], 4'h0)
      @(negedge sys_clk) up_sdi = 1'b1;
      host.close_frame();
   endtask

   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      #400000;
      err_total++;
      end_sim();
   end

   initial begin
      sys_clk = 1'b0;
      up_sdi = 1'b1;
      conv_done = 1'b0;
      // Reset rises after time zero so the asynchronous clears see an edge
      #1;
      reset = 1'b1;
      repeat (20) @(posedge sys_clk);
      @(negedge sys_clk) reset = 1'b0;
      repeat (4) @(negedge sys_clk);
      `CHK({sdo, up_sdo, up_cs_n, conv_start, conv_busy}, 5'b11100)
      `CHK(cfg, 48'h0)
      host.wake(1);
      t_write();
      t_bad_write();
      t_read();
      t_bad_cmd();
      t_poll();
      end_sim();
   end
endmodule
